// file: src/eag_cfg.svh
// constants for the effective address generator
`ifndef EAG_CFG_SVH
`define EAG_CFG_SVH

// =====================================================
// mode field codes
`define EAG_MODE_DDIR 3'h0
`define EAG_MODE_ADIR 3'h1
`define EAG_MODE_IND 3'h2
`define EAG_MODE_POST 3'h3
`define EAG_MODE_PRE 3'h4
`define EAG_MODE_DISP 3'h5
`define EAG_MODE_IDX 3'h6
`define EAG_MODE_SPEC 3'h7

// =====================================================
// special mode codes held in the register field
`define EAG_SPEC_ABSW 3'h0
`define EAG_SPEC_ABSL 3'h1
`define EAG_SPEC_PCD 3'h2
`define EAG_SPEC_PCX 3'h3
`define EAG_SPEC_IMM 3'h4

// =====================================================
// field positions in the operation word and extension word
`define EAG_OP_MODE_HI 5
`define EAG_OP_MODE_LO 3
`define EAG_OP_REG_HI 2
`define EAG_OP_REG_LO 0
`define EAG_X_REG_HI 15
`define EAG_X_REG_LO 12
`define EAG_X_LONG 11

// =====================================================
// stack register number, steps, space codes, reset values
`define EAG_STACK_REG 3'h7
`define EAG_STEP_BYTE 3'h1
`define EAG_STEP_WORD 3'h2
`define EAG_STEP_LONG 3'h4
`define EAG_EXT_STRIDE 32'h0000_0002
`define EAG_FC_DATA 2'h1
`define EAG_FC_PROG 2'h2
`define EAG_REG_RESET 32'h0000_0000

`endif

// file: src/eag_pkg.sv
// types shared by the effective address generator
package eag_pkg;

  // =====================================================
  // operand size and sequencer state
  typedef enum logic [1:0] {EAG_SZ_BYTE, EAG_SZ_WORD, EAG_SZ_LONG} eag_size_t;
  typedef enum logic [2:0] {EAG_IDLE, EAG_EXT1, EAG_EXT2, EAG_CALC, EAG_DONE} eag_state_t;

endpackage

// file: src/eag_step.sv
// address register step amount by operand size
`timescale 1ns/100ps
`default_nettype none
`include "eag_cfg.svh"
module eag_step (
  // request
  input wire eag_pkg::eag_size_t size,
  input wire logic is_stack,
  // result
  output logic [2:0] step
);
  import eag_pkg::*;

  // byte on the stack register steps by two to keep word alignment
  always_comb begin
    case (size)
      EAG_SZ_BYTE: step = is_stack ? `EAG_STEP_WORD : `EAG_STEP_BYTE;
      EAG_SZ_WORD: step = `EAG_STEP_WORD;
      default: step = `EAG_STEP_LONG;
    endcase
  end
endmodule
`default_nettype wire

// file: src/eag_regfile.sv
// data and address registers with two stack pointers
`timescale 1ns/100ps
`default_nettype none
`include "eag_cfg.svh"
module eag_regfile (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // privilege
  input wire logic priv_bit,
  // address register read
  input wire logic [2:0] an_idx,
  output logic [31:0] an_val,
  // general read, bit 3 selects the address bank
  input wire logic [3:0] gp_idx,
  output logic [31:0] gp_val,
  // address register update from the generator
  input wire logic an_we,
  input wire logic [2:0] an_wr_idx,
  input wire logic [31:0] an_wr_val,
  // execution write
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire eag_pkg::eag_size_t wr_size,
  input wire logic [31:0] wr_data
);
  import eag_pkg::*;

  logic [31:0] data_ff [8];
  logic [31:0] addr_ff [7];
  logic [31:0] priv_sp_ff;
  logic [31:0] unpriv_sp_ff;
  logic [31:0] nxt_data;

  // stack register reads the pointer chosen by privilege
  function automatic logic [31:0] rd_addr(input logic [2:0] i);
    if (i == `EAG_STACK_REG) begin
      return priv_bit ? priv_sp_ff : unpriv_sp_ff;
    end
    return addr_ff[i];
  endfunction

  assign an_val = rd_addr(an_idx);
  assign gp_val = gp_idx[3] ? rd_addr(gp_idx[2:0]) : data_ff[gp_idx[2:0]];

  // byte and word data writes change only the low part of the register, long writes replace it
  always_comb begin
    nxt_data = data_ff[wr_idx[2:0]];
    case (wr_size)
      EAG_SZ_BYTE: nxt_data[7:0] = wr_data[7:0];
      EAG_SZ_WORD: nxt_data[15:0] = wr_data[15:0];
      default: nxt_data = wr_data;
    endcase
  end

  // register update, generator side effect wins on the same register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) data_ff[i] <= `EAG_REG_RESET;
      for (int i = 0; i < 7; i++) addr_ff[i] <= `EAG_REG_RESET;
      priv_sp_ff <= `EAG_REG_RESET;
      unpriv_sp_ff <= `EAG_REG_RESET;
    end else begin
      if (wr_en && !wr_idx[3]) begin
        data_ff[wr_idx[2:0]] <= nxt_data;
      end
      if (wr_en && wr_idx[3] && !(an_we && an_wr_idx == wr_idx[2:0])) begin
        if (wr_idx[2:0] != `EAG_STACK_REG) addr_ff[wr_idx[2:0]] <= wr_data;
        else if (priv_bit) priv_sp_ff <= wr_data;
        else unpriv_sp_ff <= wr_data;
      end
      if (an_we) begin
        if (an_wr_idx != `EAG_STACK_REG) addr_ff[an_wr_idx] <= an_wr_val;
        else if (priv_bit) priv_sp_ff <= an_wr_val;
        else unpriv_sp_ff <= an_wr_val;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/eag_top.sv
// effective address decoder and operand address generator
// =====================================================
// Notes on behaviour
// - effective address is a 3-bit mode and 3-bit register from the op word.
// - modes 000 to 110 pick register direct, indirect and indexed forms.
// - mode 111 uses the register field to pick a special mode.
// - register direct takes the numbered data or address register.
// - postincrement uses the register then adds 1, 2 or 4 by size.
// - postincrement of the stack register by a byte adds two.
// - predecrement subtracts 1, 2 or 4 first and uses the new value.
// - predecrement of the stack register by a byte subtracts two.
// - displacement adds one sign-extended 16-bit extension word to the register.
// - index mode adds register, sign-extended low byte and index register.
// - absolute short sign-extends one extension word as the address.
// - absolute long joins two extension words, first word high.
// - instruction pointer displacement adds the sign-extended word to the extension word address.
// - instruction pointer index adds extension word address, low byte and index register.
// - immediate takes low byte, one word, or two words high first.
// - extension words are fetched from the words after the op word.
// - reads are data space except instruction pointer relative; writes are data space.
// - memory and absolute modes are program references for jumps.
// - space indication outputs show the space of the operand cycle.
// - stack register is privileged or unprivileged pointer by privilege bit.
// - stack pushes move the stack pointer toward lower addresses.
// - only status word instructions may reach the status word via immediate field.
// - data registers supply low byte or low word, upper bits untouched.
`timescale 1ns/100ps
`default_nettype none
`include "eag_cfg.svh"
module eag_top (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // request
  input wire logic start,
  input wire logic [15:0] op_word,
  input wire logic [31:0] op_addr,
  input wire eag_pkg::eag_size_t op_size,
  input wire logic is_jump,
  input wire logic is_write,
  input wire logic status_insn,
  input wire logic priv_bit,
  // extension word fetch
  output logic ext_req,
  output logic [31:0] ext_addr,
  input wire logic ext_valid,
  input wire logic [15:0] ext_word,
  // register write from execution
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire eag_pkg::eag_size_t wr_size,
  input wire logic [31:0] wr_data,
  // result
  output logic busy,
  output logic done,
  output logic illegal,
  output logic mem_ref,
  output logic status_ref,
  output logic [31:0] ea_addr,
  output logic [31:0] operand,
  output logic [2:0] space_code
);
  import eag_pkg::*;

  // =====================================================
  // reset synchroniser
  logic rst_meta_ff;
  logic rst_n;

  // release reset through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // =====================================================
  // captured request
  eag_state_t state_ff;
  logic [2:0] mode_ff;
  logic [2:0] reg_ff;
  eag_size_t size_ff;
  logic jump_ff;
  logic write_ff;
  logic status_ff;
  logic [31:0] ext_addr_ff;
  logic [31:0] ext1_addr_ff;
  logic [15:0] ext1_ff;
  logic [15:0] ext2_ff;
  logic [1:0] need_ext;
  logic bad_ea;
  logic [1:0] need_ext_ff;

  // extension word count from the decoded mode
  always_comb begin
    need_ext = 2'h0;
    bad_ea = 1'b0;
    case (op_word[`EAG_OP_MODE_HI:`EAG_OP_MODE_LO])
      `EAG_MODE_DISP, `EAG_MODE_IDX: need_ext = 2'h1;
      `EAG_MODE_SPEC: begin
        case (op_word[`EAG_OP_REG_HI:`EAG_OP_REG_LO])
          `EAG_SPEC_ABSW, `EAG_SPEC_PCD, `EAG_SPEC_PCX: need_ext = 2'h1;
          `EAG_SPEC_ABSL: need_ext = 2'h2;
          `EAG_SPEC_IMM: need_ext = (op_size == EAG_SZ_LONG) ? 2'h2 : 2'h1;
          default: bad_ea = 1'b1;
        endcase
      end
      default: need_ext = 2'h0;
    endcase
  end

  // sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= EAG_IDLE;
    end else begin
      case (state_ff)
        EAG_IDLE: begin
          if (start && bad_ea) state_ff <= EAG_DONE;
          else if (start && need_ext != 2'h0) state_ff <= EAG_EXT1;
          else if (start) state_ff <= EAG_CALC;
        end
        EAG_EXT1: begin
          if (ext_valid) state_ff <= (need_ext_ff == 2'h2) ? EAG_EXT2 : EAG_CALC;
        end
        EAG_EXT2: begin
          if (ext_valid) state_ff <= EAG_CALC;
        end
        EAG_CALC: state_ff <= EAG_DONE;
        EAG_DONE: state_ff <= EAG_IDLE;
        default: state_ff <= EAG_IDLE;
      endcase
    end
  end

  // capture the operation word fields at start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= 3'h0;
      reg_ff <= 3'h0;
      size_ff <= EAG_SZ_BYTE;
      jump_ff <= 1'b0;
      write_ff <= 1'b0;
      status_ff <= 1'b0;
      need_ext_ff <= 2'h0;
    end else if (state_ff == EAG_IDLE && start) begin
      mode_ff <= op_word[`EAG_OP_MODE_HI:`EAG_OP_MODE_LO];
      reg_ff <= op_word[`EAG_OP_REG_HI:`EAG_OP_REG_LO];
      size_ff <= op_size;
      jump_ff <= is_jump;
      write_ff <= is_write;
      status_ff <= status_insn;
      need_ext_ff <= need_ext;
    end
  end

  // extension words follow the operation word in the stream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_addr_ff <= 32'h0000_0000;
      ext1_addr_ff <= 32'h0000_0000;
      ext1_ff <= 16'h0000;
      ext2_ff <= 16'h0000;
    end else if (state_ff == EAG_IDLE && start) begin
      ext_addr_ff <= op_addr + `EAG_EXT_STRIDE;
      ext1_addr_ff <= op_addr + `EAG_EXT_STRIDE;
    end else if (ext_req && ext_valid) begin
      ext_addr_ff <= ext_addr_ff + `EAG_EXT_STRIDE;
      if (state_ff == EAG_EXT1) ext1_ff <= ext_word;
      else ext2_ff <= ext_word;
    end
  end

  assign ext_req = (state_ff == EAG_EXT1) || (state_ff == EAG_EXT2);
  assign ext_addr = ext_addr_ff;
  assign busy = (state_ff != EAG_IDLE);

  // =====================================================
  // register file and step
  logic [31:0] an_val;
  logic [31:0] gp_val;
  logic [3:0] gp_idx;
  logic an_we;
  logic [31:0] an_wr_val;
  logic [2:0] step;
  logic [31:0] step32;

  // general port serves data and address register direct and the index register
  assign gp_idx = (mode_ff == `EAG_MODE_DDIR) ? {1'b0, reg_ff} :
                  (mode_ff == `EAG_MODE_ADIR) ? {1'b1, reg_ff} :
                  ext1_ff[`EAG_X_REG_HI:`EAG_X_REG_LO];

  eag_regfile u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .priv_bit(priv_bit),
    .an_idx(reg_ff),
    .an_val(an_val),
    .gp_idx(gp_idx),
    .gp_val(gp_val),
    .an_we(an_we),
    .an_wr_idx(reg_ff),
    .an_wr_val(an_wr_val),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_size(wr_size),
    .wr_data(wr_data)
  );

  eag_step u_step (
    .size(size_ff),
    .is_stack(reg_ff == `EAG_STACK_REG),
    .step(step)
  );

  assign step32 = {29'h0, step};

  // =====================================================
  // address formation
  logic [31:0] disp16;
  logic [31:0] disp8;
  logic [31:0] index_val;
  logic [31:0] nxt_ea;
  logic [31:0] nxt_operand;
  logic nxt_mem;
  logic nxt_prog;
  logic nxt_status;

  assign disp16 = {{16{ext1_ff[15]}}, ext1_ff};
  assign disp8 = {{24{ext1_ff[7]}}, ext1_ff[7:0]};
  assign index_val = ext1_ff[`EAG_X_LONG] ? gp_val : {{16{gp_val[15]}}, gp_val[15:0]};

  // address, operand and space per mode
  always_comb begin
    nxt_ea = 32'h0000_0000;
    nxt_operand = 32'h0000_0000;
    nxt_mem = 1'b1;
    nxt_prog = 1'b0;
    nxt_status = 1'b0;
    an_wr_val = an_val;
    an_we = 1'b0;
    case (mode_ff)
      `EAG_MODE_DDIR: begin
        nxt_mem = 1'b0;
        case (size_ff)
          EAG_SZ_BYTE: nxt_operand = {24'h0, gp_val[7:0]};
          EAG_SZ_WORD: nxt_operand = {16'h0, gp_val[15:0]};
          default: nxt_operand = gp_val;
        endcase
      end
      `EAG_MODE_ADIR: begin
        nxt_mem = 1'b0;
        nxt_operand = (size_ff == EAG_SZ_LONG) ? gp_val : {16'h0, gp_val[15:0]};
      end
      `EAG_MODE_IND: nxt_ea = an_val;
      `EAG_MODE_POST: begin
        nxt_ea = an_val;
        an_wr_val = an_val + step32;
        an_we = (state_ff == EAG_CALC);
      end
      `EAG_MODE_PRE: begin
        an_wr_val = an_val - step32;
        nxt_ea = an_wr_val;
        an_we = (state_ff == EAG_CALC);
      end
      `EAG_MODE_DISP: nxt_ea = an_val + disp16;
      `EAG_MODE_IDX: nxt_ea = an_val + disp8 + index_val;
      default: begin
        case (reg_ff)
          `EAG_SPEC_ABSW: nxt_ea = disp16;
          `EAG_SPEC_ABSL: nxt_ea = {ext1_ff, ext2_ff};
          `EAG_SPEC_PCD: begin
            nxt_ea = ext1_addr_ff + disp16;
            nxt_prog = 1'b1;
          end
          `EAG_SPEC_PCX: begin
            nxt_ea = ext1_addr_ff + disp8 + index_val;
            nxt_prog = 1'b1;
          end
          `EAG_SPEC_IMM: begin
            nxt_mem = 1'b0;
            nxt_status = status_ff;
            case (size_ff)
              EAG_SZ_BYTE: nxt_operand = {24'h0, ext1_ff[7:0]};
              EAG_SZ_WORD: nxt_operand = {16'h0, ext1_ff};
              default: nxt_operand = {ext1_ff, ext2_ff};
            endcase
          end
          default: nxt_mem = 1'b0;
        endcase
      end
    endcase
    // jumps fetch program from any memory or absolute address
    if (jump_ff && nxt_mem) nxt_prog = 1'b1;
    if (write_ff) nxt_prog = 1'b0;
  end

  // =====================================================
  // result registers
  logic done_ff;
  logic illegal_ff;
  logic mem_ff;
  logic status_ref_ff;
  logic [31:0] ea_ff;
  logic [31:0] operand_ff;
  logic [2:0] space_ff;

  // results load in the calc cycle and stand until the next request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_ff <= 32'h0000_0000;
      operand_ff <= 32'h0000_0000;
      mem_ff <= 1'b0;
      status_ref_ff <= 1'b0;
      space_ff <= 3'h0;
    end else if (state_ff == EAG_CALC) begin
      ea_ff <= nxt_ea;
      operand_ff <= nxt_operand;
      mem_ff <= nxt_mem;
      status_ref_ff <= nxt_status;
      space_ff <= {priv_bit, nxt_prog ? `EAG_FC_PROG : `EAG_FC_DATA};
    end else if (state_ff == EAG_IDLE && start) begin
      mem_ff <= 1'b0;
      status_ref_ff <= 1'b0;
    end
  end

  // completion and illegal pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == EAG_CALC) || (state_ff == EAG_IDLE && start && bad_ea);
      illegal_ff <= (state_ff == EAG_IDLE && start && bad_ea);
    end
  end

  assign done = done_ff;
  assign illegal = illegal_ff;
  assign mem_ref = mem_ff;
  assign status_ref = status_ref_ff;
  assign ea_addr = ea_ff;
  assign operand = operand_ff;
  assign space_code = space_ff;

endmodule
`default_nettype wire

// file: test/eag_top_props.sv
// protocol and decode checks for the effective address generator
`timescale 1ns/100ps
`default_nettype none
module eag_top_props (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // request
  input wire logic start,
  input wire logic [15:0] op_word,
  input wire logic [31:0] op_addr,
  input wire logic is_write,
  // extension fetch
  input wire logic ext_req,
  input wire logic [31:0] ext_addr,
  input wire logic ext_valid,
  // result
  input wire logic busy,
  input wire logic done,
  input wire logic illegal,
  input wire logic mem_ref,
  input wire logic [2:0] space_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [5:0] ea_ff;
  logic wr_ff;
  // =====================================================
  // remember the field and direction of the accepted request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ea_ff <= 6'h00;
      wr_ff <= 1'b0;
    end else if (start && !busy) begin
      ea_ff <= op_word[5:0];
      wr_ff <= is_write;
    end
  end
  // =====================================================
  // assertions
  a_noext_timing: assert property (start && !busy && op_word[5:3] < 3'h5 |=> busy ##1 done && !illegal)
    else $error("short mode did not finish on time");
  a_illegal_decode: assert property (start && !busy && op_word[5:0] > 6'h3c |=> done && illegal)
    else $error("reserved special code not flagged");
  a_illegal_with_done: assert property (illegal |-> done)
    else $error("illegal flag without done");
  a_first_ext: assert property (start && !busy && (op_word[5:3] == 3'h5 || op_word[5:3] == 3'h6)
    |=> ext_req && ext_addr == $past(op_addr) + 32'h0000_0002)
    else $error("extension word not asked after op word");
  a_ext_hold: assert property (ext_req && !ext_valid |=> ext_req && $stable(ext_addr))
    else $error("extension request dropped or moved");
  a_done_pulse: assert property (done |=> !done && !busy)
    else $error("done not a single pulse");
  a_pc_space: assert property (done && !illegal && !wr_ff && (ea_ff == 6'h3a || ea_ff == 6'h3b)
    |-> space_code[1:0] == 2'h2)
    else $error("instruction pointer relative read not program space");
  a_write_space: assert property (done && !illegal && wr_ff && ea_ff[5:4] != 2'h0 && ea_ff != 6'h3c
    |-> space_code[1:0] == 2'h1)
    else $error("write not in data space");
  a_direct_nomem: assert property (done && ea_ff[5:4] == 2'h0 |-> !mem_ref)
    else $error("register direct flagged as memory");
endmodule
bind eag_top eag_top_props u_eag_top_props (.clk(clk), .resetn(resetn), .start(start),
  .op_word(op_word), .op_addr(op_addr), .is_write(is_write), .ext_req(ext_req),
  .ext_addr(ext_addr), .ext_valid(ext_valid), .busy(busy), .done(done), .illegal(illegal),
  .mem_ref(mem_ref), .space_code(space_code));
`default_nettype wire

// file: test/test_effective_address_generator.sv
// self-checking bench for the effective address generator
`timescale 1ns/100ps
`default_nettype none
module test_effective_address_generator;
  import eag_pkg::*;
  typedef struct {logic [5:0] op; eag_size_t sz; logic jmp, wr, st; logic [15:0] x1, x2;
    logic [31:0] ev; logic [1:0] sp; logic ill, mem;} eag_row_t;
  logic clk = 1'b0, resetn = 1'b0, start = 1'b0, is_jump = 1'b0, is_write = 1'b0;
  logic status_insn = 1'b0, priv_bit = 1'b1, ext_valid = 1'b0, wr_en = 1'b0;
  logic [15:0] op_word = 16'h0000, ext_word = 16'h0000;
  logic [31:0] op_addr = 32'h0000_0100, wr_data = 32'h0000_0000;
  logic [3:0] wr_idx = 4'h0;
  eag_size_t op_size = EAG_SZ_LONG, wr_size = EAG_SZ_LONG;
  logic ext_req, busy, done, illegal, mem_ref, status_ref;
  logic [31:0] ext_addr, ea_addr, operand;
  logic [2:0] space_code;
  int bad_count = 0, check_count = 0;
  eag_row_t rows [$] = '{
    '{6'h03, EAG_SZ_LONG, 0, 0, 0, 0, 0, 32'h1234_5678, 0, 0, 0},
    '{6'h03, EAG_SZ_BYTE, 0, 0, 0, 0, 0, 32'h0000_0078, 0, 0, 0},
    '{6'h03, EAG_SZ_WORD, 0, 0, 0, 0, 0, 32'h0000_5678, 0, 0, 0},
    '{6'h0a, EAG_SZ_LONG, 0, 0, 0, 0, 0, 32'h0000_1000, 0, 0, 0},
    '{6'h12, EAG_SZ_LONG, 0, 0, 0, 0, 0, 32'h0000_1000, 1, 0, 1},
    '{6'h12, EAG_SZ_LONG, 1, 0, 0, 0, 0, 32'h0000_1000, 2, 0, 1},
    '{6'h12, EAG_SZ_LONG, 1, 1, 0, 0, 0, 32'h0000_1000, 1, 0, 1},
    '{6'h1a, EAG_SZ_WORD, 0, 0, 0, 0, 0, 32'h0000_1000, 1, 0, 1},
    '{6'h12, EAG_SZ_LONG, 0, 0, 0, 0, 0, 32'h0000_1002, 1, 0, 1},
    '{6'h1a, EAG_SZ_BYTE, 0, 0, 0, 0, 0, 32'h0000_1002, 1, 0, 1},
    '{6'h12, EAG_SZ_LONG, 0, 0, 0, 0, 0, 32'h0000_1003, 1, 0, 1},
    '{6'h22, EAG_SZ_LONG, 0, 0, 0, 0, 0, 32'h0000_0fff, 1, 0, 1},
    '{6'h2a, EAG_SZ_LONG, 0, 0, 0, 16'hfffe, 0, 32'h0000_0ffd, 1, 0, 1},
    '{6'h32, EAG_SZ_LONG, 0, 0, 0, 16'h10f0, 0, 32'h0000_0fff, 1, 0, 1},
    '{6'h38, EAG_SZ_LONG, 0, 0, 0, 16'h8000, 0, 32'hffff_8000, 1, 0, 1},
    '{6'h38, EAG_SZ_LONG, 1, 0, 0, 16'h8000, 0, 32'hffff_8000, 2, 0, 1},
    '{6'h39, EAG_SZ_LONG, 0, 0, 0, 16'h1234, 16'h5678, 32'h1234_5678, 1, 0, 1},
    '{6'h3a, EAG_SZ_LONG, 0, 0, 0, 16'h0010, 0, 32'h0000_0112, 2, 0, 1},
    '{6'h3a, EAG_SZ_LONG, 0, 1, 0, 16'h0010, 0, 32'h0000_0112, 1, 0, 1},
    '{6'h3b, EAG_SZ_LONG, 0, 0, 0, 16'h1004, 0, 32'h0000_0116, 2, 0, 1},
    '{6'h3c, EAG_SZ_BYTE, 0, 0, 1, 16'habcd, 0, 32'h0000_00cd, 0, 0, 0},
    '{6'h3c, EAG_SZ_WORD, 0, 0, 0, 16'habcd, 0, 32'h0000_abcd, 0, 0, 0},
    '{6'h3c, EAG_SZ_LONG, 0, 0, 1, 16'h1234, 16'h5678, 32'h1234_5678, 0, 0, 0},
    '{6'h3d, EAG_SZ_LONG, 0, 0, 0, 0, 0, 0, 0, 1, 0},
    '{6'h3e, EAG_SZ_LONG, 0, 0, 0, 0, 0, 0, 0, 1, 0},
    '{6'h3f, EAG_SZ_LONG, 0, 0, 0, 0, 0, 0, 0, 1, 0}};
  // =====================================================
  // design under test
  eag_top u_eag_top (.clk(clk), .resetn(resetn), .start(start), .op_word(op_word),
    .op_addr(op_addr), .op_size(op_size), .is_jump(is_jump), .is_write(is_write),
    .status_insn(status_insn), .priv_bit(priv_bit), .ext_req(ext_req), .ext_addr(ext_addr),
    .ext_valid(ext_valid), .ext_word(ext_word), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_size(wr_size), .wr_data(wr_data), .busy(busy), .done(done), .illegal(illegal),
    .mem_ref(mem_ref), .status_ref(status_ref), .ea_addr(ea_addr), .operand(operand),
    .space_code(space_code));
  // clock
  initial begin
    forever #4 clk = ~clk;
  end
  // =====================================================
  // helper tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] i, input eag_size_t s, input logic [31:0] d);
    @(posedge clk); #1;
    wr_en = 1'b1; wr_idx = i; wr_size = s; wr_data = d;
    @(posedge clk); #1;
    wr_en = 1'b0;
  endtask
  task automatic run_ea(input logic [5:0] op, input eag_size_t sz, input logic jmp, wr, st,
    input logic [15:0] x1, x2);
    int n;
    int k;
    @(posedge clk); #1;
    op_word = {10'h000, op}; op_size = sz; is_jump = jmp; is_write = wr; status_insn = st;
    start = 1'b1;
    @(posedge clk); #1;
    start = 1'b0;
    n = 0;
    // hand out extension words in stream order until done
    for (k = 0; k < 20 && done !== 1'b1; k++) begin
      ext_valid = (ext_req === 1'b1);
      ext_word = (n == 0) ? x1 : x2;
      if (ext_req === 1'b1) n++;
      @(posedge clk); #1;
    end
    ext_valid = 1'b0;
    ext_word = ~ext_word;
    chk({31'h0, done}, 32'h1);
  endtask
  task automatic ea_is(input logic [5:0] op, input eag_size_t sz, input logic [31:0] ev);
    run_ea(op, sz, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
    chk(ea_addr, ev);
  endtask
  task finish_test;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    #80000;
    bad_count++;
    finish_test;
  end
  // =====================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk);
    wr(4'h3, EAG_SZ_LONG, 32'h1234_5678);
    wr(4'h1, EAG_SZ_LONG, 32'h0000_0010);
    wr(4'ha, EAG_SZ_LONG, 32'h0000_1000);
    wr(4'hf, EAG_SZ_LONG, 32'h0000_2000);
    foreach (rows[i]) begin
      run_ea(rows[i].op, rows[i].sz, rows[i].jmp, rows[i].wr, rows[i].st,
        rows[i].x1, rows[i].x2);
      if (rows[i].ill) chk({31'h0, illegal}, 32'h1);
      else if (rows[i].mem) begin
        chk(ea_addr, rows[i].ev);
        chk({29'h0, space_code}, {29'h0, priv_bit, rows[i].sp});
      end else chk(operand, rows[i].ev);
      chk({31'h0, status_ref}, {31'h0, rows[i].st && rows[i].op == 6'h3c});
      chk({31'h0, mem_ref}, {31'h0, rows[i].mem});
    end
    // stack pointer keeps word alignment on byte steps
    ea_is(6'h1f, EAG_SZ_BYTE, 32'h0000_2000);
    ea_is(6'h17, EAG_SZ_LONG, 32'h0000_2002);
    ea_is(6'h27, EAG_SZ_BYTE, 32'h0000_2000);
    ea_is(6'h27, EAG_SZ_WORD, 32'h0000_1ffe);
    // unprivileged pointer is a separate register
    priv_bit = 1'b0;
    ea_is(6'h17, EAG_SZ_LONG, 32'h0000_0000);
    wr(4'hf, EAG_SZ_LONG, 32'h0000_3000);
    ea_is(6'h17, EAG_SZ_LONG, 32'h0000_3000);
    priv_bit = 1'b1;
    ea_is(6'h17, EAG_SZ_LONG, 32'h0000_1ffe);
    // byte write keeps the upper bits of a data register
    wr(4'h3, EAG_SZ_BYTE, 32'hffff_ffaa);
    run_ea(6'h03, EAG_SZ_LONG, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
    chk(operand, 32'h1234_56aa);
    // reset in mid-run clears the registers
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({30'h0, busy, done}, 32'h0);
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    ea_is(6'h12, EAG_SZ_LONG, 32'h0000_0000);
    finish_test;
  end
endmodule
`default_nettype wire
